// file: rtl/fpu_port_pkg.sv
// Purpose: Shared constants and types for the coprocessor host port
// Assumes: 8-bit host data bus, byte-wide operand stack
// Notes:   Status layout and stack depth are local choices
`default_nettype none
package fpu_port_pkg;
	localparam int DATA_W        = 8;
	localparam int OPC_W         = 7;
	localparam int ERR_W         = 3;
	localparam int CMD_SRQ_BIT   = 7;
	localparam int STACK_BYTES   = 16;
	// Status byte field positions
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_SIGN_BIT = 6;
	localparam int STAT_ZERO_BIT = 5;
	localparam int STAT_ERR_LSB  = 0;
	// Error flag positions inside the error field
	localparam int ERR_DIV0_BIT  = 0;
	localparam int ERR_OVF_BIT   = 1;
	localparam int ERR_UNF_BIT   = 2;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
	localparam logic [ERR_W-1:0]  ERR_NONE     = 3'h0;
	localparam logic [1:0]        RST_SYNC_CLR = 2'h0;

	// Host access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WR_HOLD,
		ST_RD_HOLD
	} port_state_e;
endpackage
`default_nettype wire

// file: rtl/stack_if.sv
// Purpose: Carrier between the port sequencer and the operand stack
// Assumes: Push and pop are one-cycle strobes, never both at once
// Notes:   Read data shows the current top byte combinationally
`default_nettype none
interface stack_if #(
	parameter int DW = 8
);
	logic          push;
	logic          pop;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport ctrl  (output push, output pop, output wdata, input rdata);
	modport store (input push, input pop, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/operand_stack.sv
// Purpose: Byte-wide LIFO holding operands pushed by the host
// Assumes: Reset is the synchronised copy from the top module
// Notes:   Pointer wraps on over/underflow; contents are not cleared
`default_nettype none
module operand_stack
	import fpu_port_pkg::*;
#(
	parameter int DEPTH = STACK_BYTES
) (
	// Clock and reset
	input  wire logic   i_sys_clk,
	input  wire logic   i_rst_n,
	// Stack access
	stack_if.store      stk
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] PTR_ONE  = AW'(1);
	localparam logic [AW-1:0] PTR_ZERO = AW'(0);

	logic [AW-1:0]     ptr_q;
	logic [DATA_W-1:0] mem_q [DEPTH];

	// Pointer returns to empty on reset
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_q <= PTR_ZERO;
		end else if (stk.push) begin
			ptr_q <= ptr_q + PTR_ONE;
		end else if (stk.pop) begin
			ptr_q <= ptr_q - PTR_ONE;
		end
	end

	// Storage; left unreset since contents may be disturbed anyway
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge i_sys_clk) begin
			if (stk.push && ptr_q == AW'(i)) begin
				mem_q[i] <= stk.wdata;
			end
		end
	end

	// Last byte pushed comes out first, so MSB leads on pop
	assign stk.rdata = mem_q[ptr_q - PTR_ONE];
endmodule
`default_nettype wire

// file: rtl/fpu_host_handshake_port.sv
// Purpose: Host handshake port of a stack floating-point coprocessor
// Assumes: Host pins are synchronous to i_sys_clk
// Notes:   Arithmetic core sits outside; it sees start and opcode, returns done, error flags, sign and zero
//
// Operation
// - Reset aborts command, clears status, stack pointer
// - After reset done, fault, service request low
// - Select and strobes pick push, pop, command, status
// - Done flag rises when command finishes
// - Done clears on ack low, access, reset
// - Done is flop; tied-low ack gives pulse
// - Service request set only if enable bit set
// - Service request cleared by ack low, reset
// - Completion without enable bit drops service request
// - Bus bit 0 LSB, high means one
// - Pop returns most significant byte first
// - Fault rises on divide zero, overflow, underflow
// - Fault cleared by status read or reset
// - Fault follows error bits mid-execution
// - Selected with strobes idle pulls wait low
// - Write releases wait after capture
// - Read releases wait with data valid
// - Wait stays low between accesses while selected
// - Command low seven bits opcode, top bit enable
// - Done clears on read fall, write rise
`default_nettype none
module fpu_host_handshake_port
	import fpu_port_pkg::*;
#(
	parameter int STACK_DEPTH = STACK_BYTES
) (
	// Clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset_n,
	// Host access control
	input  wire logic              i_cs_n,
	input  wire logic              i_cmd_sel,
	input  wire logic              i_rd_n,
	input  wire logic              i_wr_n,
	output var  logic              o_wait_n,
	// Host data bus, split into three signals
	input  wire logic [DATA_W-1:0] i_host_data_bus,
	output var  logic [DATA_W-1:0] o_host_data_bus,
	output var  logic              o_host_data_oe,
	// Completion and fault handshake
	output var  logic              o_done,
	input  wire logic              i_done_ack_n,
	output var  logic              o_service_request,
	input  wire logic              i_service_ack_n,
	output var  logic              o_fault,
	// Arithmetic core side
	output var  logic              o_cmd_start,
	output var  logic [OPC_W-1:0]  o_cmd_opcode,
	input  wire logic              i_cmd_done,
	input  wire logic [ERR_W-1:0]  i_err_flags,
	input  wire logic              i_result_sign,
	input  wire logic              i_result_zero
);
	// Reset synchroniser and its released copy
	logic [1:0] rst_sync_q;
	logic       rst_n;

	// Sequencer state
	port_state_e state_q;
	port_state_e state_d;
	logic        rd_n_prev_q;

	// Command and status state
	logic             busy_q;
	logic             srq_en_q;
	logic [ERR_W-1:0] err_q;
	logic             sign_q;
	logic             zero_q;
	logic [DATA_W-1:0] status_byte;

	// Decoded access terms
	logic sel;
	logic wr_req;
	logic rd_req;
	logic accept_wr;
	logic accept_rd;
	logic rd_fall;
	logic wr_rise;
	logic cmd_fin;
	logic err_hit;
	logic status_rd;
	logic wait_n_d;

	stack_if #(.DW(DATA_W)) stk ();

	// Assert asynchronously, release through two flops
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync_q <= RST_SYNC_CLR;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'h1};
		end
	end
	// Host keeps reset long enough; no stretching here
	assign rst_n = rst_sync_q[1];

	// Operand storage
	operand_stack #(
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_n),
		.stk       (stk)
	);

	// Transfer type from select and strobes; both low is ignored
	assign sel    = !i_cs_n;
	assign wr_req = sel && !i_wr_n && i_rd_n;
	assign rd_req = sel && !i_rd_n && i_wr_n;

	// Data and command writes stall while a command still runs;
	// status reads are served at any time
	assign accept_wr = (state_q == ST_IDLE) && wr_req && !busy_q;
	assign accept_rd = (state_q == ST_IDLE) && rd_req &&
	                   (i_cmd_sel || !busy_q);
	assign status_rd = accept_rd && i_cmd_sel;

	// Edges that clear the done flag, only while selected
	assign rd_fall = rd_req && rd_n_prev_q;
	assign wr_rise = (state_q == ST_WR_HOLD) && i_wr_n && sel;

	// Completion and error events from the core
	assign cmd_fin = busy_q && i_cmd_done;
	assign err_hit = busy_q && (|i_err_flags);

	// Push on data write, pop on data read
	assign stk.push  = accept_wr && !i_cmd_sel;
	assign stk.pop   = accept_rd && !i_cmd_sel;
	assign stk.wdata = i_host_data_bus;

	// Status byte seen by the host
	always_comb begin
		status_byte                = STATUS_RESET;
		status_byte[STAT_BUSY_BIT] = busy_q;
		status_byte[STAT_SIGN_BIT] = sign_q;
		status_byte[STAT_ZERO_BIT] = zero_q;
		status_byte[STAT_ERR_LSB +: ERR_W] = err_q;
	end

	// Previous read strobe, for the falling edge
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_n_prev_q <= 1'h1;
		end else begin
			rd_n_prev_q <= i_rd_n;
		end
	end

	// Next sequencer state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (accept_wr) begin
					state_d = ST_WR_HOLD;
				end else if (accept_rd) begin
					state_d = ST_RD_HOLD;
				end
			end
			ST_WR_HOLD: begin
				if (i_wr_n) begin
					state_d = ST_IDLE;
				end
			end
			ST_RD_HOLD: begin
				if (i_rd_n) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Wait: low while selected and idle or stalled, high once the
	// access is taken until its strobe returns
	always_comb begin
		wait_n_d = 1'h1;
		unique case (state_q)
			ST_IDLE: begin
				// Anticipate a transfer; stay low while stalled
				wait_n_d = !sel || accept_wr || accept_rd;
			end
			ST_WR_HOLD: begin
				// Capture done; host may now raise the strobe
				wait_n_d = i_wr_n ? !sel : 1'h1;
			end
			ST_RD_HOLD: begin
				// Data is on the bus while wait is high
				wait_n_d = i_rd_n ? !sel : 1'h1;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_wait_n <= 1'h1;
		end else begin
			o_wait_n <= wait_n_d;
		end
	end

	// Read data and drive enable, valid in the same edge as wait
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_host_data_bus <= STATUS_RESET;
			o_host_data_oe  <= 1'h0;
		end else if (accept_rd) begin
			o_host_data_bus <= i_cmd_sel ? status_byte : stk.rdata;
			o_host_data_oe  <= 1'h1;
		end else if (state_q == ST_RD_HOLD && i_rd_n) begin
			o_host_data_oe  <= 1'h0; // Release once strobe rises
		end
	end

	// Command entry: opcode to the core, enable bit kept
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_cmd_start  <= 1'h0;
			o_cmd_opcode <= OPC_W'(0);
			srq_en_q     <= 1'h0;
		end else begin
			o_cmd_start <= accept_wr && i_cmd_sel;
			if (accept_wr && i_cmd_sel) begin
				o_cmd_opcode <= i_host_data_bus[OPC_W-1:0];
				srq_en_q     <= i_host_data_bus[CMD_SRQ_BIT];
			end
		end
	end

	// Busy from command entry until the core reports done;
	// reset drops it, which aborts the command
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'h0;
		end else if (accept_wr && i_cmd_sel) begin
			busy_q <= 1'h1;
		end else if (cmd_fin) begin
			busy_q <= 1'h0;
		end
	end

	// Error bits update during execution; a new command starts clean
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_q <= ERR_NONE;
		end else if (accept_wr && i_cmd_sel) begin
			err_q <= ERR_NONE;
		end else if (busy_q) begin
			err_q <= err_q | i_err_flags;
		end
	end

	// Sign and zero captured at completion
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sign_q <= 1'h0;
			zero_q <= 1'h0;
		end else if (cmd_fin) begin
			sign_q <= i_result_sign;
			zero_q <= i_result_zero;
		end
	end

	// Done flop: set wins over clear, so a tied-low acknowledge
	// still yields a one-clock pulse
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_done <= 1'h0;
		end else if (cmd_fin) begin
			o_done <= 1'h1;
		end else if (!i_done_ack_n || rd_fall || wr_rise) begin
			o_done <= 1'h0;
		end
	end

	// Service request follows the enable bit of the finishing command
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_service_request <= 1'h0;
		end else if (cmd_fin && srq_en_q) begin
			o_service_request <= 1'h1;
		end else if (cmd_fin || !i_service_ack_n) begin
			// Held-low ack lets each set through for one clock
			o_service_request <= 1'h0;
		end
	end

	// Fault rises as soon as any error bit sets, even mid-command;
	// a status read in the same cycle loses to the new error
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_fault <= 1'h0;
		end else if (err_hit) begin
			o_fault <= 1'h1;
		end else if (status_rd) begin
			o_fault <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// file: bench/fpu_core_model.sv
// Purpose: Behavioural arithmetic core answering command starts
// Assumes: Opcode held by the port while a command runs
// Notes:   Latency 2 to 9 cycles so both quick and slow answers occur
`default_nettype none
module fpu_core_model
	import fpu_port_pkg::*;
(
	// Clock
	input  wire logic             i_sys_clk,
	// Command in
	input  wire logic             i_start,
	input  wire logic [OPC_W-1:0] i_opcode,
	// Result out
	output var  logic             o_done = 1'b0,
	output var  logic [ERR_W-1:0] o_err = 3'h0,
	output var  logic             o_sign,
	output var  logic             o_zero
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q = 4'h0;
	// Error lands a cycle before the end, as in a real mid-run fault
	always @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		o_err <= ERR_NONE;
		if (i_start)
			cnt_q <= 4'h2 + {1'b0, i_opcode[2:0]};
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
		if (cnt_q == 4'h2 && i_opcode[6:5] == 2'h3)
			o_err <= i_opcode[2:0];
		if (cnt_q == 4'h1)
			o_done <= 1'b1;
	end
	// Result flags straight from opcode bits
	assign o_sign = i_opcode[3];
	assign o_zero = i_opcode[4];
endmodule
`default_nettype wire

// file: bench/fpu_host_handshake_port_chk.sv
// Purpose: Port protocol checks for the host handshake port
// Assumes: Sees top-level ports only
// Notes:   First edges after release still see the synced reset
`default_nettype none
module fpu_host_handshake_port_chk
	import fpu_port_pkg::*;
(
	// Clock and reset
	input wire logic              i_sys_clk,
	input wire logic              i_reset_n,
	// Host side
	input wire logic              i_cs_n,
	input wire logic              i_cmd_sel,
	input wire logic              i_rd_n,
	input wire logic              i_wr_n,
	input wire logic              o_wait_n,
	input wire logic [DATA_W-1:0] o_host_data_bus,
	input wire logic              o_host_data_oe,
	// Flags and core
	input wire logic              o_done,
	input wire logic              i_done_ack_n,
	input wire logic              o_service_request,
	input wire logic              i_service_ack_n,
	input wire logic              o_fault,
	input wire logic              i_cmd_done,
	input wire logic [ERR_W-1:0]  i_err_flags
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	logic [1:0] up_q;
	// Age since release; masks the sync stage
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	end
	sequence s_idle;
		!i_cs_n && i_rd_n && i_wr_n;
	endsequence
	sequence s_rd_on;
		!i_rd_n && o_host_data_oe;
	endsequence
	property p_quiet;
		$rose(i_reset_n)
			|-> (!o_done && !o_fault && !o_service_request)[*2];
	endproperty
	property p_idle;
		(up_q == 2'h3 && !i_cs_n && i_rd_n && i_wr_n) ##1 s_idle[*2]
			|-> !o_wait_n;
	endproperty
	property p_wr_ack;
		!i_cs_n && !i_wr_n && i_rd_n |-> ##[0:40] o_wait_n;
	endproperty
	property p_rd_hold;
		s_rd_on ##1 !i_rd_n |-> o_wait_n && $stable(o_host_data_bus);
	endproperty
	property p_rd_clr;
		$rose(o_host_data_oe) && i_cmd_sel && !$past(i_cmd_done)
			|-> !o_done && ($past(i_err_flags) != ERR_NONE || !o_fault);
	endproperty
	property p_cs_off;
		i_cs_n |=> o_wait_n;
	endproperty
	property p_done_ack;
		!i_done_ack_n && !i_cmd_done |=> !o_done;
	endproperty
	property p_srq_ack;
		!i_service_ack_n && !i_cmd_done |=> !o_service_request;
	endproperty
	property p_fault_set;
		$rose(o_fault) |-> $past(i_err_flags) != ERR_NONE;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("flags up after reset");
	a_idle: assert property (p_idle)
		else $error("wait not low while selected");
	a_cs_off: assert property (p_cs_off)
		else $error("wait low while deselected");
	a_wr_ack: assert property (p_wr_ack)
		else $error("write never acknowledged");
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data not held");
	a_rd_clr: assert property (p_rd_clr)
		else $error("status read left flags set");
	a_done_ack: assert property (p_done_ack)
		else $error("done not cleared by ack");
	a_srq_ack: assert property (p_srq_ack)
		else $error("request not cleared by ack");
	a_fault_set: assert property (p_fault_set)
		else $error("fault without error");
endmodule
bind fpu_host_handshake_port fpu_host_handshake_port_chk u_chk (.*);
`default_nettype wire

// file: bench/fpu_host_handshake_port_bench.sv
// Purpose: Self-checking bench for the host handshake port
// Assumes: Core side answered by a behavioural model
// Notes:   Chip select stays low except for one short check
`default_nettype none
module fpu_host_handshake_port_bench
	import fpu_port_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, sel = 1'b0;
	logic             rd_n = 1'b1, wr_n = 1'b1, dack_n = 1'b1, sack_n = 1'b1;
	logic             wait_n, oe, done, srq, fault, start, cdone, sgn, zro;
	logic [7:0]       wdat = 8'h00, rdat, r, b [8];
	logic [7:0]       hand [5] = '{8'h82, 8'h13, 8'hE5, 8'h61, 8'h62};
	logic [OPC_W-1:0] opc;
	logic [ERR_W-1:0] err;
	int               n_fail = 0, n_tests = 0, s;
	// 25 MHz clock
	always #20 clk = ~clk;
	fpu_host_handshake_port dut (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n),
		.i_cmd_sel(sel), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_wait_n(wait_n),
		.i_host_data_bus(wdat), .o_host_data_bus(rdat),
		.o_host_data_oe(oe), .o_done(done), .i_done_ack_n(dack_n),
		.o_service_request(srq), .i_service_ack_n(sack_n),
		.o_fault(fault), .o_cmd_start(start), .o_cmd_opcode(opc),
		.i_cmd_done(cdone), .i_err_flags(err), .i_result_sign(sgn),
		.i_result_zero(zro)
	);
	fpu_core_model core (
		.i_sys_clk(clk), .i_start(start), .i_opcode(opc), .o_done(cdone),
		.o_err(err), .o_sign(sgn), .o_zero(zro)
	);
	// Status expected once a command has ended
	function automatic logic [7:0] exp_stat(input logic [7:0] c);
		logic [2:0] e;
		e = (c[6:5] == 2'h3) ? c[2:0] : 3'h0;
		return {1'b0, c[3], c[4], 2'h0, e};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One access; reads held a random while to prove data stands
	task automatic xfer(input logic c, input logic w, input logic [7:0] d);
		int k;
		repeat (2) @(negedge clk);
		sel = c;
		wdat = d;
		rd_n = w;
		wr_n = !w;
		for (k = 0; k < 60 && wait_n !== 1'b1; k++) @(negedge clk);
		chk(8'(k < 60), 8'h01);
		r = rdat;
		if (!w) chk(8'(oe), 8'h01);
		if (!w) repeat ($urandom_range(2)) @(negedge clk);
		rd_n = 1'b1;
		wr_n = 1'b1;
		wdat = ~d;
	endtask
	// Enter a command, await its end, then read status
	task automatic run_cmd(input logic [7:0] c);
		int k;
		logic [7:0] e;
		e = exp_stat(c);
		xfer(1'b1, 1'b1, c);
		chk(8'(opc), 8'(c[6:0]));
		for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
		chk(8'(done), 8'h01);
		chk(8'(srq), 8'(c[7]));
		chk(8'(fault), 8'(e[2:0] != 3'h0));
		@(negedge clk);
		chk(8'(done), 8'(dack_n));
		if (c[0]) begin
			sack_n = 1'b0;
			@(negedge clk);
			sack_n = 1'b1;
			chk(8'(srq), 8'h00);
		end
		xfer(1'b1, 1'b0, 8'($urandom));
		chk(r, e);
		chk(8'({done, fault}), 8'h00);
	endtask
	task automatic summarize();
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		s = $urandom(13176);
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		chk(8'({done, srq, fault}), 8'h00);
		repeat (4) @(negedge clk);
		chk(8'(wait_n), 8'h01);
		cs_n = 1'b0;
		repeat (2) @(negedge clk);
		chk(8'(wait_n), 8'h00);
		for (int n = 4; n <= 8; n += 4) begin
			for (int i = 0; i < n; i++) begin
				b[i] = 8'($urandom);
				xfer(1'b0, 1'b1, b[i]);
			end
			for (int i = n - 1; i >= 0; i--) begin
				xfer(1'b0, 1'b0, 8'($urandom));
				chk(r, b[i]);
			end
		end
		foreach (hand[i]) run_cmd(hand[i]);
		dack_n = 1'b0;
		repeat (6) run_cmd(8'($urandom));
		dack_n = 1'b1;
		// Push while busy must stall, then land
		xfer(1'b1, 1'b1, 8'h07);
		xfer(1'b0, 1'b1, 8'h5A);
		xfer(1'b0, 1'b0, 8'h00);
		chk(r, 8'h5A);
		chk(8'(done), 8'h00);
		// Reset in mid-command
		xfer(1'b1, 1'b1, 8'hE7);
		repeat (3) @(negedge clk);
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (20) @(negedge clk);
		chk(8'({done, srq, fault}), 8'h00);
		xfer(1'b1, 1'b0, 8'h00);
		chk(r, STATUS_RESET);
		summarize();
	end
	// Watchdog far beyond the expected run
	initial begin
		#300000;
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
